// >>> hdl/uiw_pkg.sv
// Purpose: Shared constants and types for the four-wire idle-wake serial port
// Assumes: 20 MHz core clock, 8N1 framing
// Notes:   Long counts are also top-level parameters so simulation can shorten them
package uiw_pkg;

    // Clock and line rate
    localparam int CLK_HZ       = 20_000_000;          // Core clock rate
    localparam int BAUD         = 115_200;             // Line rate
    localparam int BAUD_DIV     = CLK_HZ / BAUD;       // Cycles per bit
    localparam int HALF_DIV     = BAUD_DIV / 2;        // Cycles to mid start bit
    localparam int BAUD_W       = 8;                   // Baud counter width

    // Wake-up delay after the first received data while idle
    localparam int WAKE_MS      = 20;                  // Receiver re-enable delay
    localparam int WAKE_CYC     = (CLK_HZ / 1000) * WAKE_MS;
    // Inactivity before idle entry and periodic enable timing
    localparam int IDLE_US      = 10_000;              // Quiet time before idle
    localparam int IDLE_CYC     = (CLK_HZ / 1_000_000) * IDLE_US;
    localparam int WIN_PER_US   = 2_500;               // Periodic enable period
    localparam int WIN_PER_CYC  = (CLK_HZ / 1_000_000) * WIN_PER_US;
    localparam int WIN_ON_US    = 500;                 // Enabled part of each period
    localparam int WIN_ON_CYC   = (CLK_HZ / 1_000_000) * WIN_ON_US;
    localparam int CNT_W        = 20;                  // Width of long counters

    // Data path
    localparam int DATA_W       = 8;                   // Character width
    localparam int FIFO_DEPTH   = 8;                   // Transmit buffer depth

    // Reset values of pins
    localparam logic TXD_RST    = 1'b1;                // Line idles high
    localparam logic CTS_N_RST  = 1'b1;                // Clear-to-send inactive
    localparam logic RX_EN_RST  = 1'b1;                // Port starts in active mode

    // Power state of the port
    typedef enum logic [1:0] {
        UIW_ACTIVE,
        UIW_IDLE,
        UIW_WAKE
    } uiw_mode_e;

    // Serial engine state
    typedef enum logic [1:0] {
        UIW_S_IDLE,
        UIW_S_START,
        UIW_S_DATA,
        UIW_S_STOP
    } uiw_ser_e;

endpackage

// >>> hdl/uiw_port.sv
// Purpose: Device-side four-wire serial port with periodic-wake idle mode
// Assumes: Configuration inputs come from core logic on clk; pins are asynchronous
// Notes:   Transmit data passes an 8-word FIFO; receive data is a one-cycle strobe
`timescale 1ns/1ps
`default_nettype none

// Transmit buffer
module uiw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    import uiw_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // Whole state of the buffer
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // Storage
        logic [AW-1:0]               wr;    // Write pointer
        logic [AW-1:0]               rd;    // Read pointer
        logic [AW:0]                 cnt;   // Words held
    } uiw_fifo_s;

    uiw_fifo_s st;
    uiw_fifo_s next_st;

    logic push;                             // Word taken in
    logic pop;                              // Word handed out

    // Honest flags from the count
    assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.mem[st.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next-state logic
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr         = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
        end
        // Count follows both sides
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// Port top level
module uiw_port #(
    parameter int WAKE_CYCLES = uiw_pkg::WAKE_CYC,     // Receiver re-enable delay
    parameter int IDLE_CYCLES = uiw_pkg::IDLE_CYC,     // Quiet time before idle
    parameter int WIN_PERIOD  = uiw_pkg::WIN_PER_CYC,  // Periodic enable period
    parameter int WIN_ON      = uiw_pkg::WIN_ON_CYC    // Enabled part of period
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Configuration from core logic
    input  wire logic                        hw_flow_en,
    input  wire logic                        psv_idle_mode,
    input  wire logic                        serial_en,
    // Serial pins
    input  wire logic                        rxd,
    output logic                             txd,
    input  wire logic                        rts_n,
    output logic                             cts_n,
    // Transmit data from core
    input  wire logic                        tx_valid,
    input  wire logic [uiw_pkg::DATA_W-1:0]  tx_data,
    output logic                             tx_ready,
    // Receive data to core
    output logic                             rx_valid,
    output logic      [uiw_pkg::DATA_W-1:0]  rx_data,
    // Power state
    output logic                             low_power_idle,
    output logic                             rx_enabled
);
    import uiw_pkg::*;

    // Whole state of the port
    typedef struct packed {
        logic                rxd_m;      // Receive line, first stage
        logic                rxd_s;      // Receive line, synchronised
        logic                rts_m;      // RTS, first stage
        logic                rts_s;      // RTS, synchronised
        uiw_mode_e           mode;       // Power state
        logic [CNT_W-1:0]    lp_cnt;     // Quiet or wake counter
        logic [CNT_W-1:0]    win_cnt;    // Periodic enable phase
        uiw_ser_e            rx_st;      // Receiver state
        logic [BAUD_W-1:0]   rx_baud;    // Receiver bit timer
        logic [2:0]          rx_bit;     // Receiver bit index
        logic [DATA_W-1:0]   rx_sh;      // Receiver shift register
        uiw_ser_e            tx_st;      // Transmitter state
        logic [BAUD_W-1:0]   tx_baud;    // Transmitter bit timer
        logic [2:0]          tx_bit;     // Transmitter bit index
        logic [DATA_W-1:0]   tx_sh;      // Transmitter shift register
        logic                txd;        // Line output
        logic                cts_n;      // Clear-to-send output
        logic                rx_valid;   // Receive strobe
        logic [DATA_W-1:0]   rx_data;    // Received character
        logic                tx_ready;   // Buffer has room
        logic                lp_idle;    // Low-power idle flag
        logic                rx_en;      // Receiver enabled flag
    } uiw_port_s;

    uiw_port_s st;
    uiw_port_s next_st;

    logic              f_valid;          // Buffer holds a word
    logic [DATA_W-1:0] f_data;           // Oldest buffered word
    logic              f_pop;            // Transmitter takes the word
    logic              f_in_ready;       // Buffer fill-side ready
    logic              tx_allowed;       // Transmitter may start

    // Flow control gate on the transmitter
    assign tx_allowed = (st.mode == UIW_ACTIVE) && serial_en
                        && (!hw_flow_en || !st.rts_s);
    assign f_pop      = tx_allowed && (st.tx_st == UIW_S_IDLE) && f_valid;

    uiw_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (tx_valid),
        .in_data   (tx_data),
        .in_ready  (f_in_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_pop)
    );

    // Next-state logic
    always_comb begin
        next_st          = st;
        next_st.rxd_m    = rxd;
        next_st.rxd_s    = st.rxd_m;
        next_st.rts_m    = rts_n;
        next_st.rts_s    = st.rts_m;
        next_st.rx_valid = 1'b0;
        next_st.tx_ready = f_in_ready;

        // Power state
        unique case (st.mode)
            UIW_ACTIVE: begin
                // Quiet time counts only with setting 1 and no traffic
                if (!psv_idle_mode || st.rx_st != UIW_S_IDLE || st.tx_st != UIW_S_IDLE
                    || f_valid || !st.rxd_s) begin
                    next_st.lp_cnt = '0;
                end else if (st.lp_cnt == CNT_W'(IDLE_CYCLES - 1)) begin
                    next_st.mode    = UIW_IDLE;
                    next_st.lp_cnt  = '0;
                    next_st.win_cnt = '0;
                end else begin
                    next_st.lp_cnt = st.lp_cnt + 1'b1;
                end
            end
            UIW_IDLE: begin
                // Port enabled only in part of each period
                next_st.win_cnt = (st.win_cnt == CNT_W'(WIN_PERIOD - 1)) ? '0
                                  : st.win_cnt + 1'b1;
                if (!psv_idle_mode || f_valid) begin
                    // Setting dropped or own data to send
                    next_st.mode = UIW_ACTIVE;
                end else if (!st.rxd_s && st.win_cnt < CNT_W'(WIN_ON)) begin
                    // First data seen: it is only a wake-up
                    next_st.mode   = UIW_WAKE;
                    next_st.lp_cnt = '0;
                end
            end
            UIW_WAKE: begin
                // Receiver stays off for the wake delay
                if (st.lp_cnt == CNT_W'(WAKE_CYCLES - 1)) begin
                    next_st.mode   = UIW_ACTIVE;
                    next_st.lp_cnt = '0;
                end else begin
                    next_st.lp_cnt = st.lp_cnt + 1'b1;
                end
            end
            default: begin
                // Unused code falls back to active
                next_st.mode = UIW_ACTIVE;
            end
        endcase

        // Clear-to-send reflects readiness
        next_st.cts_n = !((next_st.mode == UIW_ACTIVE) && serial_en && hw_flow_en);

        // Power flags registered together with the new mode
        next_st.lp_idle = (next_st.mode != UIW_ACTIVE);
        next_st.rx_en   = (next_st.mode == UIW_ACTIVE);

        // Receiver, running only in active mode
        if (st.mode != UIW_ACTIVE || !serial_en) begin
            next_st.rx_st = UIW_S_IDLE;
        end else begin
            unique case (st.rx_st)
                UIW_S_IDLE: begin
                    // Start bit edge
                    if (!st.rxd_s) begin
                        next_st.rx_st   = UIW_S_START;
                        next_st.rx_baud = BAUD_W'(HALF_DIV - 1);
                    end
                end
                UIW_S_START: begin
                    if (st.rx_baud != '0) begin
                        next_st.rx_baud = st.rx_baud - 1'b1;
                    end else if (st.rxd_s) begin
                        next_st.rx_st = UIW_S_IDLE;                // Glitch, not a start
                    end else begin
                        next_st.rx_st   = UIW_S_DATA;
                        next_st.rx_baud = BAUD_W'(BAUD_DIV - 1);
                        next_st.rx_bit  = '0;
                    end
                end
                UIW_S_DATA: begin
                    if (st.rx_baud != '0) begin
                        next_st.rx_baud = st.rx_baud - 1'b1;
                    end else begin
                        // Least significant bit first
                        next_st.rx_sh   = {st.rxd_s, st.rx_sh[DATA_W-1:1]};
                        next_st.rx_baud = BAUD_W'(BAUD_DIV - 1);
                        next_st.rx_bit  = st.rx_bit + 1'b1;
                        if (st.rx_bit == 3'h7) begin
                            next_st.rx_st = UIW_S_STOP;
                        end
                    end
                end
                UIW_S_STOP: begin
                    if (st.rx_baud != '0) begin
                        next_st.rx_baud = st.rx_baud - 1'b1;
                    end else begin
                        // Deliver only with a valid stop bit
                        next_st.rx_st    = UIW_S_IDLE;
                        next_st.rx_valid = st.rxd_s;
                        next_st.rx_data  = st.rx_sh;
                    end
                end
            endcase
        end

        // Transmitter; a started frame always completes
        unique case (st.tx_st)
            UIW_S_IDLE: begin
                next_st.txd = TXD_RST;
                if (f_pop) begin
                    next_st.tx_st   = UIW_S_START;
                    next_st.tx_sh   = f_data;
                    next_st.tx_baud = BAUD_W'(BAUD_DIV - 1);
                    next_st.txd     = 1'b0;
                end
            end
            UIW_S_START: begin
                if (st.tx_baud != '0) begin
                    next_st.tx_baud = st.tx_baud - 1'b1;
                end else begin
                    next_st.tx_st   = UIW_S_DATA;
                    next_st.tx_baud = BAUD_W'(BAUD_DIV - 1);
                    next_st.tx_bit  = '0;
                    next_st.txd     = st.tx_sh[0];
                    next_st.tx_sh   = {1'b0, st.tx_sh[DATA_W-1:1]};
                end
            end
            UIW_S_DATA: begin
                if (st.tx_baud != '0) begin
                    next_st.tx_baud = st.tx_baud - 1'b1;
                end else if (st.tx_bit == 3'h7) begin
                    next_st.tx_st   = UIW_S_STOP;
                    next_st.tx_baud = BAUD_W'(BAUD_DIV - 1);
                    next_st.txd     = 1'b1;
                end else begin
                    next_st.tx_bit  = st.tx_bit + 1'b1;
                    next_st.tx_baud = BAUD_W'(BAUD_DIV - 1);
                    next_st.txd     = st.tx_sh[0];
                    next_st.tx_sh   = {1'b0, st.tx_sh[DATA_W-1:1]};
                end
            end
            UIW_S_STOP: begin
                if (st.tx_baud != '0) begin
                    next_st.tx_baud = st.tx_baud - 1'b1;
                end else begin
                    next_st.tx_st = UIW_S_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st       <= '0;
            st.rxd_m <= 1'b1;
            st.rxd_s <= 1'b1;
            st.rts_m <= 1'b1;
            st.rts_s <= 1'b1;
            st.mode  <= UIW_ACTIVE;
            st.rx_st <= UIW_S_IDLE;
            st.tx_st <= UIW_S_IDLE;
            st.txd   <= TXD_RST;
            st.cts_n <= CTS_N_RST;
            st.rx_en <= RX_EN_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign txd            = st.txd;
    assign cts_n          = st.cts_n;
    assign rx_valid       = st.rx_valid;
    assign rx_data        = st.rx_data;
    assign tx_ready       = st.tx_ready;
    assign low_power_idle = st.lp_idle;
    assign rx_enabled     = st.rx_en;
endmodule

`default_nettype wire

// >>> dv/uiw_port_assertions.sv
// Purpose: Concurrent checks on the idle-wake serial port pins
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached to every port instance by the bind below
`timescale 1ns/1ps
`default_nettype none
module uiw_port_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched ports
    input wire logic hw_flow_en,
    input wire logic serial_en,
    input wire logic rts_n,
    input wire logic txd,
    input wire logic cts_n,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic low_power_idle,
    input wire logic rx_enabled
);
    localparam int START_LAST = 172; // Last cycle of the start bit
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Clear-to-send tracks the new mode and last cycle's settings
    cts_follow_a: assert property ($past(rst_n) |-> cts_n ==
        !(rx_enabled && $past(serial_en) && $past(hw_flow_en)))
        else $error("cts_n disagrees with mode and settings");
    // No start bit while flow control holds the line
    tx_hold_a: assert property ($past(hw_flow_en) && $past(rts_n) && $past(rts_n, 2)
        && $past(rts_n, 3) && $past(rts_n, 4) |-> !$fell(txd))
        else $error("frame started with request-to-send inactive");
    // Start bit lasts a whole bit time
    start_bit_a: assert property ($fell(txd) |-> ##START_LAST !txd)
        else $error("start bit too short");
    // Nothing delivered while asleep
    idle_rx_a: assert property (low_power_idle && $past(low_power_idle) |-> !rx_valid)
        else $error("character delivered in idle");
    // Transmit line rests high while asleep
    idle_txd_a: assert property (low_power_idle |-> txd)
        else $error("transmit activity in idle");
    // Power flags are exclusive
    mode_excl_a: assert property (low_power_idle != rx_enabled)
        else $error("power flags not exclusive");
    // Receive strobe lasts one cycle
    rx_pulse_a: assert property (rx_valid |=> !rx_valid)
        else $error("rx_valid longer than one cycle");
    // Buffer only fills through pushes
    ready_full_a: assert property ($fell(tx_ready) |-> $past(tx_valid) || $past(tx_valid, 2))
        else $error("tx_ready fell without a push");
endmodule
bind uiw_port uiw_port_assertions u_chk (.clk(clk), .rst_n(rst_n), .hw_flow_en(hw_flow_en),
    .serial_en(serial_en), .rts_n(rts_n), .txd(txd), .cts_n(cts_n), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .low_power_idle(low_power_idle),
    .rx_enabled(rx_enabled));
`default_nettype wire

// >>> dv/uiw_dte.sv
// Purpose: Host-side serial model: sends characters, captures module output
// Assumes: 8N1 at the port's fixed bit time
// Notes:   Releases its line during reset; the module pin has a pull-up
`timescale 1ns/1ps
`default_nettype none
module uiw_dte (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Serial lines
    output wire logic rxd,
    input  wire logic txd
);
    import uiw_pkg::*;
    logic              line_q = 1'b1; // Level driven when not released
    logic [DATA_W-1:0] got[$];        // Captured characters
    // Line left floating while the module is held in reset
    assign rxd = rst_n ? line_q : 1'bz;
    // One frame, LSB first, each bit a full bit time
    task automatic send(input logic [DATA_W-1:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #2;
            line_q = f[i];
            repeat (BAUD_DIV - 1) @(posedge clk);
        end
    endtask
    // Capture of module frames, mid-bit sampling
    initial begin
        logic [DATA_W-1:0] b;
        forever begin
            @(posedge clk);
            #2;
            if (rst_n === 1'b1 && txd === 1'b0) begin
                repeat (HALF_DIV) @(posedge clk);
                for (int i = 0; i < DATA_W; i++) begin
                    repeat (BAUD_DIV) @(posedge clk);
                    #2;
                    b[i] = txd;
                end
                repeat (BAUD_DIV) @(posedge clk);
                got.push_back(b);
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the idle-wake serial port
// Assumes: Shortened wake, idle and window counts
// Notes:   Far end is the uiw_dte host model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import uiw_pkg::*;
    localparam int WAKE_T = 2000; // Shortened wake delay, still longer than a frame
    logic              clk, rst_n, hw_flow_en, psv_idle_mode, serial_en, rts_n, tx_valid;
    logic [DATA_W-1:0] tx_data, rx_data;
    logic              txd, cts_n, tx_ready, rx_valid, low_power_idle, rx_enabled;
    tri1               rxd_w;       // Module pin with pull-up
    int                n_mismatch = 0, checks_done = 0, n_rx = 0, k;
    uiw_port #(.WAKE_CYCLES(WAKE_T), .IDLE_CYCLES(40), .WIN_PERIOD(20), .WIN_ON(10)) dut (
        .clk(clk), .rst_n(rst_n), .hw_flow_en(hw_flow_en), .psv_idle_mode(psv_idle_mode),
        .serial_en(serial_en), .rxd(rxd_w), .txd(txd), .rts_n(rts_n), .cts_n(cts_n),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .low_power_idle(low_power_idle), .rx_enabled(rx_enabled));
    uiw_dte dte (.clk(clk), .rst_n(rst_n), .rxd(rxd_w), .txd(txd));
    // Clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Delivered character count
    always @(posedge clk) if (rx_valid === 1'b1) n_rx <= n_rx + 1;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Wait bound used up
    task automatic hang();
        chk(8'h00, 8'h01);
        conclude();
    endtask
    task automatic t_reset();
        chk(txd, 8'h01);
        chk(cts_n, 8'h01);
        chk(rx_valid, 8'h00);
        chk(tx_ready, 8'h00);
        rst_n = 1'b1;
        step(2);
        chk(tx_ready, 8'h01);
        chk(rx_enabled, 8'h01);
        chk(low_power_idle, 8'h00);
    endtask
    task automatic t_cts();
        step(2);
        chk(cts_n, 8'h00);
        serial_en = 1'b0;
        step(2);
        chk(cts_n, 8'h01);
        serial_en = 1'b1;
        hw_flow_en = 1'b0;
        step(2);
        chk(cts_n, 8'h01);
        hw_flow_en = 1'b1;
        step(2);
    endtask
    // Fill while stalled, then drain to the host
    task automatic t_fifo();
        int n;
        n = 0;
        rts_n = 1'b1;
        step(4);
        while (tx_ready === 1'b1 && n < 12) begin
            tx_valid = 1'b1;
            tx_data = 8'ha0 + 8'(n);
            step(1);
            tx_valid = 1'b0;
            n++;
            step(1);
        end
        chk(8'(n), 8'h08);
        step(400);
        chk(8'(dte.got.size()), 8'h00);
        rts_n = 1'b0;
        k = 0;
        while (dte.got.size() < 8) begin
            step(1);
            k++;
            if (k > 20000) hang();
        end
        for (int i = 0; i < 8; i++) chk(dte.got[i], 8'ha0 + 8'(i));
    endtask
    // One character from the host must be delivered
    task automatic t_rx_byte(input logic [7:0] b);
        fork
            dte.send(b);
        join_none
        k = 0;
        while (rx_valid !== 1'b1) begin
            step(1);
            k++;
            if (k > 2500) hang();
        end
        chk(rx_data, b);
        step(BAUD_DIV);
    endtask
    // Own data wakes an idle port and is sent
    task automatic t_idle_tx();
        int n;
        n = dte.got.size();
        hw_flow_en = 1'b0;
        psv_idle_mode = 1'b1;
        k = 0;
        while (low_power_idle !== 1'b1) begin
            step(1);
            k++;
            if (k > 500) hang();
        end
        tx_valid = 1'b1;
        tx_data = 8'h3c;
        step(1);
        tx_valid = 1'b0;
        k = 0;
        while (dte.got.size() == n) begin
            step(1);
            k++;
            if (k > 2500) hang();
        end
        chk(dte.got[n], 8'h3c);
        psv_idle_mode = 1'b0;
        hw_flow_en = 1'b1;
        step(4);
    endtask
    // Idle entry, wake character, then recognised data
    task automatic t_wake();
        int n;
        hw_flow_en = 1'b0;
        psv_idle_mode = 1'b1;
        k = 0;
        while (low_power_idle !== 1'b1) begin
            step(1);
            k++;
            if (k > 500) hang();
        end
        chk(rx_enabled, 8'h00);
        n = n_rx;
        fork
            dte.send(8'hff);
        join_none
        k = 0;
        while (rx_enabled !== 1'b1) begin
            step(1);
            k++;
            if (k > WAKE_T + 100) hang();
        end
        psv_idle_mode = 1'b0;
        chk(8'(k >= WAKE_T && k <= WAKE_T + 10), 8'h01);
        step(BAUD_DIV);
        chk(8'(n_rx - n), 8'h00);
        t_rx_byte(8'hc3);
    endtask
    initial begin
        rst_n = 1'b0;
        hw_flow_en = 1'b1;
        psv_idle_mode = 1'b0;
        serial_en = 1'b1;
        rts_n = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        step(20);
        t_reset();
        t_cts();
        t_fifo();
        t_rx_byte(8'h5a);
        t_idle_tx();
        t_wake();
        conclude();
    end
endmodule
`default_nettype wire
